/* mcir_host_model.sv */
// mcir_host_model: host side of the register access path, byte strobes.
// assumes rising-edge sampling; drives 2 ns after it.
module mcir_host_model (
    // clock
    input wire logic clk_i,
    // strobes and byte to the register bank
    output logic ptr_wr_o,
    output logic data_wr_o,
    output logic data_rd_o,
    output logic [7:0] wr_data_o,
    // read byte
    input wire logic [7:0] rd_data_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle strobes
    initial begin
        ptr_wr_o = 1'b0;
        data_wr_o = 1'b0;
        data_rd_o = 1'b0;
        wr_data_o = 8'h00;
    end

    // pointer cycle, then write cycle
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) #2;
        ptr_wr_o = 1'b1;
        wr_data_o = a;
        @(posedge clk_i) #2;
        ptr_wr_o = 1'b0;
        data_wr_o = 1'b1;
        wr_data_o = d;
        @(posedge clk_i) #2;
        data_wr_o = 1'b0;
        wr_data_o = ~d;
    endtask : put

    // pointer cycle, then read cycle
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i) #2;
        ptr_wr_o = 1'b1;
        wr_data_o = a;
        @(posedge clk_i) #2;
        ptr_wr_o = 1'b0;
        data_rd_o = 1'b1;
        wr_data_o = ~a;
        @(posedge clk_i) #2;
        data_rd_o = 1'b0;
        d = rd_data_i;
    endtask : get
endmodule : mcir_host_model

/* mcir_irq_if.sv */
// mcir_irq_if: carries status, masks and pin style from the register
// bank to the interrupt output stage.
// assumes both ends run on the same clock.
interface mcir_irq_if;
    import mcir_pkg::*;

    mcir_byte_type stat_volt;
    mcir_byte_type stat_misc;
    mcir_byte_type mask_volt;
    mcir_byte_type mask_misc;
    logic int_en;
    logic int_pol;
    logic int_hold;

    modport regs (
        output stat_volt, stat_misc, mask_volt, mask_misc, int_en, int_pol, int_hold
    );
    modport outp (
        input stat_volt, stat_misc, mask_volt, mask_misc, int_en, int_pol, int_hold
    );
endinterface : mcir_irq_if

/* mcir_irq_out.sv */
// mcir_irq_out: forms the interrupt pin from status, masks and style bits.
// assumes the pin is resolved outside from value and output enable.
module mcir_irq_out
    import mcir_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // register bank side
    mcir_irq_if.outp irq,
    // pin
    output logic int_o,
    output logic int_oe_o
);

    logic int_o_q;
    logic int_oe_q;
    logic pending;

    // any unmasked status bit pending
    assign pending = |(irq.stat_volt & ~irq.mask_volt)
                   | |(irq.stat_misc & ~irq.mask_misc);

    // ==========================================================
    // pin drive: level is the polarity, enable marks the active state
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            int_o_q <= 1'b0;
            int_oe_q <= 1'b0;
        end else begin
            int_o_q <= irq.int_pol;
            int_oe_q <= irq.int_en && !irq.int_hold && pending;
        end
    end

    assign int_o = int_o_q;
    assign int_oe_o = int_oe_q;

endmodule : mcir_irq_out

/* mcir_pkg.sv */
// mcir_pkg: register map, field positions, reset values and timing counts
// of the monitor configuration and interrupt register bank.
// assumes a 40 MHz core clock; shared by every mcir module except the host model.
package mcir_pkg;

    // ==========================================================
    // types
    typedef logic [7:0] mcir_byte_type;

    // ==========================================================
    // register indices behind the address pointer
    localparam mcir_byte_type ADDR_CONFIG = 8'h00;
    localparam mcir_byte_type ADDR_STAT_VOLT = 8'h01;
    localparam mcir_byte_type ADDR_STAT_MISC = 8'h02;
    localparam mcir_byte_type ADDR_MASK_VOLT = 8'h03;
    localparam mcir_byte_type ADDR_MASK_MISC = 8'h04;
    localparam mcir_byte_type ADDR_FAN_DIV = 8'h05;
    localparam mcir_byte_type ADDR_OT_CFG = 8'h06;
    localparam mcir_byte_type ADDR_CONV_RATE = 8'h07;
    localparam mcir_byte_type ADDR_CHAN_DIS = 8'h08;

    // ==========================================================
    // power-on values
    localparam mcir_byte_type RST_PTR = 8'h00;
    localparam mcir_byte_type RST_CONFIG = 8'h08;
    localparam mcir_byte_type RST_STAT = 8'h00;
    localparam mcir_byte_type RST_MASK = 8'h00;
    localparam mcir_byte_type RST_FAN_DIV = 8'h14;
    localparam mcir_byte_type RST_OT_CFG = 8'h01;
    localparam mcir_byte_type RST_CONV_RATE = 8'h00;
    localparam mcir_byte_type RST_CHAN_DIS = 8'h00;

    // ==========================================================
    // configuration register fields
    localparam int CFG_START = 0;
    localparam int CFG_INT_EN = 1;
    localparam int CFG_INT_POL = 2;
    localparam int CFG_INT_HOLD = 3;
    localparam int CFG_RST_PULSE = 4;
    localparam int CFG_INTR_CLR = 5;
    localparam int CFG_GEN_OUT = 6;
    localparam int CFG_INIT = 7;

    // ==========================================================
    // status / mask fields and output select fields
    localparam int ST2_HOT = 0;
    localparam int ST2_BOARD_OT = 1;
    localparam int ST2_TACH0 = 2;
    localparam int ST2_TACH1 = 3;
    localparam int ST2_INTRUSION = 4;
    localparam int ST2_OT_SHUT = 5;
    localparam int ST2_USED = 6;
    localparam int ST1_CHAIN = 7;
    localparam int MASK2_HOT_MODE = 6;
    localparam int MASK2_OT_MODE = 7;
    localparam int FANDIV_RST_EN = 7;
    localparam int FANDIV_OT_EN = 6;

    // ==========================================================
    // timing
    localparam int CLK_HZ = 40_000_000;
    localparam int PULSE_TIME_MS = 10;
    localparam int PULSE_CYCLES = (PULSE_TIME_MS * CLK_HZ + 999) / 1000;

endpackage : mcir_pkg

/* mcir_pulse_timer.sv */
// mcir_pulse_timer: one-shot busy window of a fixed number of cycles.
// assumes start is a single-cycle request; abort ends the window at once.
module mcir_pulse_timer
    import mcir_pkg::*;
#(
    parameter int CYCLES = PULSE_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic start_i,
    input wire logic abort_i,
    // status
    output logic busy_o
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_q;
    logic busy_q;

    // ==========================================================
    // window counter: busy for exactly CYCLES cycles
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || abort_i) begin
            busy_q <= 1'b0;
            cnt_q <= '0;
        end else if (!busy_q) begin
            busy_q <= start_i;
            cnt_q <= '0;
        end else if (cnt_q == LAST) begin
            busy_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    assign busy_o = busy_q;

endmodule : mcir_pulse_timer

/* mcir_regs.sv */
// mcir_regs: configuration and interrupt register bank of a hardware
// monitor, reached through an address pointer from the serial bus front end.
// assumes the front end delivers one-cycle pointer write, data write and
// data read strobes, and that monitor events arrive synchronous to CLK_I.
//
// Summary of operation
// - configuration resets to 08h: output hold set, monitoring stopped
// - output select resets to 14h, overtemp config to 01h, rate and disable to 0
// - start bit one runs monitoring; zero means shutdown
// - clearing start leaves the interrupt pin as it is
// - interrupt enable bit zero keeps the pin from ever asserting
// - style bit: one active-high, released while inactive; zero active-low open drain
// - hold bit deasserts the pin, keeps status, halts monitoring
// - reset bit gives a 10 ms low pulse when enabled, then self-clears
// - intrusion clear bit pulls intrusion line low 10 ms, then self-clears
// - general output bit one drives its pin low, zero releases it
// - init bit restores power-on values and never reads back as one
// - voltage status bits 0 to 6 set on limit violation, read only
// - voltage status bit 7 sets on low chained interrupt input
// - misc status bit 0 flags hot limit, mode from mask bit 6
// - misc status bit 1 sets on board overtemp input
// - misc status bits 2 and 3 set on tach limit violation
// - misc status bit 4 sets while intrusion input is high and no intrusion clear pulse runs
// - misc status bit 5 flags overtemp-shutdown limit, mode from mask bit 7
// - mask bit one keeps the status bit off the pin
// - reading a status register returns it and clears it
// - hot mode zero repeats every conversion, one fires once per excursion
module mcir_regs
    import mcir_pkg::*;
#(
    parameter int PULSE_LEN = PULSE_CYCLES
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // register access from the serial front end
    input wire logic PTR_WR_I,
    input wire logic DATA_WR_I,
    input wire logic DATA_RD_I,
    input wire logic [7:0] WR_DATA_I,
    output logic [7:0] RD_DATA_O,
    output logic [7:0] PTR_O,
    // monitoring loop
    input wire logic CONV_DONE_I,
    input wire logic [6:0] VOLT_VIOL_I,
    input wire logic [1:0] TACH_VIOL_I,
    input wire logic HOT_OVER_I,
    input wire logic OT_OVER_I,
    output logic MONITOR_RUN_O,
    output logic [7:0] CONV_RATE_O,
    output logic [7:0] CHAN_DIS_O,
    output logic [7:0] FAN_DIV_O,
    output logic [7:0] OT_CFG_O,
    // external interrupt sources
    input wire logic CHAIN_INT_N_I,
    input wire logic BOARD_OVERTEMP_INPUT_N_I,
    input wire logic INTRUSION_INPUT_I,
    // pins
    output logic INTRUSION_INPUT_O,
    output logic INTRUSION_INPUT_OE_O,
    output logic INT_O,
    output logic INT_OE_O,
    output logic RST_OUT_O,
    output logic RST_OUT_OE_O,
    output logic GENERAL_OUTPUT_PIN_O,
    output logic GENERAL_OUTPUT_PIN_OE_O
);

    // ==========================================================
    // address decode helper
    function automatic logic hit(input mcir_byte_type ptr, input mcir_byte_type idx);
        hit = (ptr == idx);
    endfunction : hit

    // ==========================================================
    // declarations
    mcir_byte_type ptr_q;
    mcir_byte_type cfg_q;
    mcir_byte_type stat_q [2];
    mcir_byte_type stat_set [2];
    logic stat_rd [2];
    mcir_byte_type mask_volt_q;
    mcir_byte_type mask_misc_q;
    mcir_byte_type fan_div_q;
    mcir_byte_type ot_cfg_q;
    mcir_byte_type rate_q;
    mcir_byte_type chan_dis_q;
    mcir_byte_type rd_data_q;
    mcir_byte_type rd_mux;
    logic [1:0] armed_q;
    logic [1:0] temp_over;
    logic [1:0] temp_mode;
    logic [1:0] temp_evt;
    logic wr_cfg;
    logic init;
    logic mon_active;
    logic rst_busy;
    logic intr_busy;
    logic rst_pin_q;
    logic intr_pin_q;
    logic gen_pin_q;
    logic mon_run_q;

    mcir_irq_if irq ();

    // ==========================================================
    // strobes
    assign wr_cfg = DATA_WR_I && hit(ptr_q, ADDR_CONFIG);
    assign init = wr_cfg && WR_DATA_I[CFG_INIT];
    // measurement events count only while running and not held
    assign mon_active = cfg_q[CFG_START] && !cfg_q[CFG_INT_HOLD];
    assign stat_rd[0] = DATA_RD_I && hit(ptr_q, ADDR_STAT_VOLT);
    assign stat_rd[1] = DATA_RD_I && hit(ptr_q, ADDR_STAT_MISC);

    // ==========================================================
    // address pointer
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            ptr_q <= RST_PTR;
        end else if (PTR_WR_I) begin
            ptr_q <= WR_DATA_I;
        end
    end

    // ==========================================================
    // configuration: pulse bits read back from their timers
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I || init) begin
            cfg_q <= RST_CONFIG;
        end else if (wr_cfg) begin
            cfg_q[CFG_START] <= WR_DATA_I[CFG_START];
            cfg_q[CFG_INT_EN] <= WR_DATA_I[CFG_INT_EN];
            cfg_q[CFG_INT_POL] <= WR_DATA_I[CFG_INT_POL];
            cfg_q[CFG_INT_HOLD] <= WR_DATA_I[CFG_INT_HOLD];
            cfg_q[CFG_GEN_OUT] <= WR_DATA_I[CFG_GEN_OUT];
        end
    end

    // ==========================================================
    // plain read/write registers
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I || init) begin
            mask_volt_q <= RST_MASK;
            mask_misc_q <= RST_MASK;
            fan_div_q <= RST_FAN_DIV;
            ot_cfg_q <= RST_OT_CFG;
            rate_q <= RST_CONV_RATE;
            chan_dis_q <= RST_CHAN_DIS;
        end else if (DATA_WR_I) begin
            if (hit(ptr_q, ADDR_MASK_VOLT)) begin
                mask_volt_q <= WR_DATA_I;
            end else if (hit(ptr_q, ADDR_MASK_MISC)) begin
                mask_misc_q <= WR_DATA_I;
            end else if (hit(ptr_q, ADDR_FAN_DIV)) begin
                fan_div_q <= WR_DATA_I;
            end else if (hit(ptr_q, ADDR_OT_CFG)) begin
                ot_cfg_q <= WR_DATA_I;
            end else if (hit(ptr_q, ADDR_CONV_RATE)) begin
                rate_q <= WR_DATA_I;
            end else if (hit(ptr_q, ADDR_CHAN_DIS)) begin
                chan_dis_q <= WR_DATA_I;
            end
        end
    end

    // ==========================================================
    // temperature events: index 0 hot limit, index 1 overtemp shutdown
    assign temp_over = {OT_OVER_I, HOT_OVER_I};
    assign temp_mode = {mask_misc_q[MASK2_OT_MODE], mask_misc_q[MASK2_HOT_MODE]};

    generate
        for (genvar t = 0; t < 2; t++) begin : g_temp
            // default mode re-raises each conversion, one-time mode once
            assign temp_evt[t] = mon_active && CONV_DONE_I && temp_over[t]
                               && (!temp_mode[t] || armed_q[t]);

            // one-time arm: spent on an event, rearmed below hysteresis
            always_ff @(posedge CLK_I) begin
                if (!RSTN_I || init) begin
                    armed_q[t] <= 1'b1;
                end else if (!temp_over[t]) begin
                    armed_q[t] <= 1'b1;
                end else if (temp_evt[t]) begin
                    armed_q[t] <= 1'b0;
                end
            end
        end
    endgenerate

    // ==========================================================
    // status set terms
    always_comb begin
        stat_set[0] = '0;
        stat_set[1] = '0;
        stat_set[0][6:0] = VOLT_VIOL_I & {7{mon_active}};
        stat_set[0][ST1_CHAIN] = !CHAIN_INT_N_I;
        stat_set[1][ST2_HOT] = temp_evt[0];
        stat_set[1][ST2_BOARD_OT] = !BOARD_OVERTEMP_INPUT_N_I;
        stat_set[1][ST2_TACH0] = TACH_VIOL_I[0] && mon_active;
        stat_set[1][ST2_TACH1] = TACH_VIOL_I[1] && mon_active;
        stat_set[1][ST2_INTRUSION] = INTRUSION_INPUT_I && !intr_busy;
        stat_set[1][ST2_OT_SHUT] = temp_evt[1];
    end

    // ==========================================================
    // sticky status, cleared by a read; a new event wins over the clear
    generate
        for (genvar s = 0; s < 2; s++) begin : g_stat
            always_ff @(posedge CLK_I) begin
                if (!RSTN_I || init) begin
                    stat_q[s] <= RST_STAT;
                end else if (stat_rd[s]) begin
                    stat_q[s] <= stat_set[s];
                end else begin
                    stat_q[s] <= stat_q[s] | stat_set[s];
                end
            end
        end
    endgenerate

    // ==========================================================
    // read data: unmapped indices read zero
    always_comb begin
        if (hit(ptr_q, ADDR_CONFIG)) begin
            rd_mux = cfg_q;
            rd_mux[CFG_RST_PULSE] = rst_busy;
            rd_mux[CFG_INTR_CLR] = intr_busy;
            rd_mux[CFG_INIT] = 1'b0;
        end else if (hit(ptr_q, ADDR_STAT_VOLT)) begin
            rd_mux = stat_q[0];
        end else if (hit(ptr_q, ADDR_STAT_MISC)) begin
            rd_mux = stat_q[1];
            rd_mux[7:ST2_USED] = '0;
        end else if (hit(ptr_q, ADDR_MASK_VOLT)) begin
            rd_mux = mask_volt_q;
        end else if (hit(ptr_q, ADDR_MASK_MISC)) begin
            rd_mux = mask_misc_q;
        end else if (hit(ptr_q, ADDR_FAN_DIV)) begin
            rd_mux = fan_div_q;
        end else if (hit(ptr_q, ADDR_OT_CFG)) begin
            rd_mux = ot_cfg_q;
        end else if (hit(ptr_q, ADDR_CONV_RATE)) begin
            rd_mux = rate_q;
        end else if (hit(ptr_q, ADDR_CHAN_DIS)) begin
            rd_mux = chan_dis_q;
        end else begin
            rd_mux = '0;
        end
    end

    // read data register, loaded on each read strobe
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            rd_data_q <= '0;
        end else if (DATA_RD_I) begin
            rd_data_q <= rd_mux;
        end
    end

    // ==========================================================
    // self-clearing pulse timers
    mcir_pulse_timer #(
        .CYCLES(PULSE_LEN)
    ) u_rst_timer (
        .clk_i(CLK_I),
        .rst_n_i(RSTN_I),
        .start_i(wr_cfg && WR_DATA_I[CFG_RST_PULSE] && !init),
        .abort_i(init),
        .busy_o(rst_busy)
    );

    mcir_pulse_timer #(
        .CYCLES(PULSE_LEN)
    ) u_intr_timer (
        .clk_i(CLK_I),
        .rst_n_i(RSTN_I),
        .start_i(wr_cfg && WR_DATA_I[CFG_INTR_CLR] && !init),
        .abort_i(init),
        .busy_o(intr_busy)
    );

    // ==========================================================
    // pin drivers, all open drain pulling low, and the monitor run flag
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            rst_pin_q <= 1'b0;
            intr_pin_q <= 1'b0;
            gen_pin_q <= 1'b0;
            mon_run_q <= 1'b0;
        end else begin
            rst_pin_q <= rst_busy && fan_div_q[FANDIV_RST_EN]
                       && !fan_div_q[FANDIV_OT_EN];
            intr_pin_q <= intr_busy;
            gen_pin_q <= cfg_q[CFG_GEN_OUT];
            mon_run_q <= mon_active;
        end
    end

    // ==========================================================
    // interrupt output stage
    assign irq.stat_volt = stat_q[0];
    assign irq.stat_misc = {2'b00, stat_q[1][ST2_USED-1:0]};
    assign irq.mask_volt = mask_volt_q;
    assign irq.mask_misc = mask_misc_q;
    assign irq.int_en = cfg_q[CFG_INT_EN];
    assign irq.int_pol = cfg_q[CFG_INT_POL];
    assign irq.int_hold = cfg_q[CFG_INT_HOLD];

    mcir_irq_out u_irq_out (
        .clk_i(CLK_I),
        .rst_n_i(RSTN_I),
        .irq(irq.outp),
        .int_o(INT_O),
        .int_oe_o(INT_OE_O)
    );

    // ==========================================================
    // output assignments
    assign RD_DATA_O = rd_data_q;
    assign PTR_O = ptr_q;
    assign MONITOR_RUN_O = mon_run_q;
    assign CONV_RATE_O = rate_q;
    assign CHAN_DIS_O = chan_dis_q;
    assign FAN_DIV_O = fan_div_q;
    assign OT_CFG_O = ot_cfg_q;
    assign RST_OUT_O = 1'b0; // pin only ever pulled low
    assign RST_OUT_OE_O = rst_pin_q;
    assign INTRUSION_INPUT_O = 1'b0;
    assign INTRUSION_INPUT_OE_O = intr_pin_q;
    assign GENERAL_OUTPUT_PIN_O = 1'b0;
    assign GENERAL_OUTPUT_PIN_OE_O = gen_pin_q;

endmodule : mcir_regs

/* mcir_regs_asserts.sv */
// mcir_regs_asserts: port checker of mcir_regs.
// assumes one clock and sync active-low reset.
module mcir_regs_chk
    import mcir_pkg::*;
#(
    parameter int PULSE_LEN = PULSE_CYCLES
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // register access
    input wire logic PTR_WR_I,
    input wire logic DATA_WR_I,
    input wire logic DATA_RD_I,
    input wire logic [7:0] WR_DATA_I,
    input wire logic [7:0] RD_DATA_O,
    input wire logic [7:0] PTR_O,
    input wire logic MONITOR_RUN_O,
    // pins
    input wire logic INT_O,
    input wire logic INT_OE_O,
    input wire logic RST_OUT_O,
    input wire logic RST_OUT_OE_O,
    input wire logic INTRUSION_INPUT_O,
    input wire logic INTRUSION_INPUT_OE_O,
    input wire logic GENERAL_OUTPUT_PIN_O,
    input wire logic GENERAL_OUTPUT_PIN_OE_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    // ==========================================================
    // pulse length counters
    int rst_len_q;
    int intr_len_q;

    // cycles each pin has been pulled low so far
    always_ff @(posedge CLK_I) begin
        rst_len_q <= (!RSTN_I || !RST_OUT_OE_O) ? 0 : rst_len_q + 1;
        intr_len_q <= (!RSTN_I || !INTRUSION_INPUT_OE_O) ? 0 : intr_len_q + 1;
    end

    // ==========================================================
    // assertions
    a_reset_vals: assert property ($rose(RSTN_I) |-> PTR_O == 8'h00 && RD_DATA_O == 8'h00
        && !MONITOR_RUN_O && !INT_OE_O && !RST_OUT_OE_O)
        else $error("bad reset values");
    a_ptr_load: assert property (PTR_WR_I |=> PTR_O == $past(WR_DATA_I))
        else $error("pointer not loaded");
    a_read_stands: assert property (!$past(DATA_RD_I) |-> $stable(RD_DATA_O))
        else $error("read byte moved");
    a_run_on_write: assert property ($changed(MONITOR_RUN_O) |-> $past(DATA_WR_I, 2))
        else $error("run moved without write");
    a_pol_on_write: assert property ($changed(INT_O) |-> $past(DATA_WR_I, 2))
        else $error("style moved without write");
    a_gpo_on_write: assert property ($changed(GENERAL_OUTPUT_PIN_OE_O) |-> $past(DATA_WR_I, 2))
        else $error("output pin moved without write");
    a_gpo_low: assert property (GENERAL_OUTPUT_PIN_OE_O |-> !GENERAL_OUTPUT_PIN_O)
        else $error("general output driven high");
    a_rst_low: assert property (RST_OUT_OE_O |-> !RST_OUT_O)
        else $error("reset output driven high");
    a_rst_len: assert property ($fell(RST_OUT_OE_O) && !$past(DATA_WR_I, 2) |-> rst_len_q == PULSE_LEN)
        else $error("reset pulse length wrong");
    a_intr_low: assert property (INTRUSION_INPUT_OE_O |-> !INTRUSION_INPUT_O)
        else $error("intrusion line driven high");
    a_intr_len: assert property ($fell(INTRUSION_INPUT_OE_O) && !$past(DATA_WR_I, 2)
        |-> intr_len_q == PULSE_LEN)
        else $error("intrusion clear length wrong");
endmodule : mcir_regs_chk

bind mcir_regs mcir_regs_chk #(.PULSE_LEN(PULSE_LEN)) i_chk (.CLK_I, .RSTN_I, .PTR_WR_I,
    .DATA_WR_I, .DATA_RD_I, .WR_DATA_I, .RD_DATA_O, .PTR_O, .MONITOR_RUN_O, .INT_O, .INT_OE_O,
    .RST_OUT_O, .RST_OUT_OE_O, .INTRUSION_INPUT_O, .INTRUSION_INPUT_OE_O,
    .GENERAL_OUTPUT_PIN_O, .GENERAL_OUTPUT_PIN_OE_O);

/* tb.sv */
// tb: self-checking bench for the mcir_regs register bank.
// assumes host model and bound checker.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PL = 8;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ptr_wr, data_wr, data_rd, conv, hot, ot, chain_n, bto_n, intr;
    logic run, int_v, int_oe, rst_oe, intr_oe, gpo_oe;
    logic [7:0] wr_data, rd_data, conv_rate, chan_dis;
    logic [6:0] volt;
    logic [1:0] tach;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] dflt [0:9] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h01, 8'h00,
        8'h00, 8'h00};

    // 40 MHz clock
    always #12.5 clk = ~clk;

    mcir_host_model i_host (.clk_i(clk), .ptr_wr_o(ptr_wr), .data_wr_o(data_wr),
        .data_rd_o(data_rd), .wr_data_o(wr_data), .rd_data_i(rd_data));

    mcir_regs #(.PULSE_LEN(PL)) i_dut (.CLK_I(clk), .RSTN_I(rst_n), .PTR_WR_I(ptr_wr),
        .DATA_WR_I(data_wr), .DATA_RD_I(data_rd), .WR_DATA_I(wr_data), .RD_DATA_O(rd_data),
        .PTR_O(), .CONV_DONE_I(conv), .VOLT_VIOL_I(volt), .TACH_VIOL_I(tach),
        .HOT_OVER_I(hot), .OT_OVER_I(ot), .MONITOR_RUN_O(run), .CONV_RATE_O(conv_rate),
        .CHAN_DIS_O(chan_dis), .FAN_DIV_O(), .OT_CFG_O(), .CHAIN_INT_N_I(chain_n),
        .BOARD_OVERTEMP_INPUT_N_I(bto_n), .INTRUSION_INPUT_I(intr), .INTRUSION_INPUT_O(),
        .INTRUSION_INPUT_OE_O(intr_oe), .INT_O(int_v), .INT_OE_O(int_oe), .RST_OUT_O(),
        .RST_OUT_OE_O(rst_oe), .GENERAL_OUTPUT_PIN_O(), .GENERAL_OUTPUT_PIN_OE_O(gpo_oe));

    // ==========================================================
    // helpers
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.get(a, d);
        chk(d, exp);
    endtask : rc

    // one-cycle event pulse
    task automatic ev(input logic [6:0] v, input logic c, input logic k);
        tick(1);
        volt = v;
        chain_n = ~c;
        conv = k;
        tick(1);
        volt = 7'h00;
        chain_n = 1'b1;
        conv = 1'b0;
        tick(3);
    endtask : ev

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        {conv, volt, tach, hot, ot, intr} = '0;
        chain_n = 1'b1;
        bto_n = 1'b1;
        tick(5);
        rst_n = 1'b1;
        foreach (dflt[i]) rc(8'(i), dflt[i]);
        i_host.put(8'h03, 8'h5a);
        i_host.put(8'h07, 8'h3c);
        i_host.put(8'h08, 8'hc3);
        i_host.put(8'h01, 8'hff);
        rc(8'h03, 8'h5a);
        rc(8'h01, 8'h00);
        chk(conv_rate, 8'h3c);
        chk(chan_dis, 8'hc3);
        // limits would be loaded here before start is set
        i_host.put(8'h03, 8'h00);
        i_host.put(8'h00, 8'h01);
        ev(7'h00, 1'b1, 1'b0);
        chk({7'h00, int_oe}, 8'h00);
        rc(8'h01, 8'h80);
        i_host.put(8'h00, 8'h03);
        ev(7'h00, 1'b1, 1'b0);
        chk({7'h00, int_oe}, 8'h01);
        chk({7'h00, int_v}, 8'h00);
        i_host.put(8'h00, 8'h02);
        tick(2);
        chk({6'h00, int_oe, run}, 8'h02);
        rc(8'h01, 8'h80);
        rc(8'h01, 8'h00);
        chk({7'h00, int_oe}, 8'h00);
        i_host.put(8'h03, 8'h80);
        ev(7'h00, 1'b1, 1'b0);
        chk({7'h00, int_oe}, 8'h00);
        rc(8'h01, 8'h80);
        i_host.put(8'h03, 8'h00);
        i_host.put(8'h00, 8'h07);
        ev(7'h41, 1'b0, 1'b0);
        chk({5'h00, run, int_oe, int_v}, 8'h07);
        rc(8'h01, 8'h41);
        i_host.put(8'h00, 8'h0f);
        ev(7'h01, 1'b1, 1'b0);
        chk({6'h00, run, int_oe}, 8'h00);
        rc(8'h01, 8'h80);
        // all misc sources at once
        i_host.put(8'h00, 8'h01);
        tick(1);
        {tach, bto_n, intr, hot, ot, conv} = 7'b11_0_1_111;
        tick(1);
        {tach, bto_n, intr, hot, ot, conv} = 7'b00_1_0_000;
        tick(2);
        rc(8'h02, 8'h3f);
        hot = 1'b1;
        ev(7'h00, 1'b0, 1'b1);
        rc(8'h02, 8'h01);
        ev(7'h00, 1'b0, 1'b1);
        rc(8'h02, 8'h01);
        i_host.put(8'h04, 8'h40);
        hot = 1'b0;
        ev(7'h00, 1'b0, 1'b1);
        hot = 1'b1;
        ev(7'h00, 1'b0, 1'b1);
        rc(8'h02, 8'h01);
        ev(7'h00, 1'b0, 1'b1);
        rc(8'h02, 8'h00);
        hot = 1'b0;
        // timed pulses and general output pin
        i_host.put(8'h05, 8'h80);
        i_host.put(8'h00, 8'h10);
        tick(1);
        chk(8'(rst_oe), 8'h01);
        rc(8'h00, 8'h10);
        tick(PL);
        chk(8'(rst_oe), 8'h00);
        rc(8'h00, 8'h00);
        i_host.put(8'h05, 8'h14);
        i_host.put(8'h00, 8'h10);
        tick(1);
        chk(8'(rst_oe), 8'h00);
        tick(PL);
        i_host.put(8'h00, 8'h20);
        tick(1);
        chk(8'(intr_oe), 8'h01);
        tick(PL + 1);
        chk(8'(intr_oe), 8'h00);
        rc(8'h00, 8'h00);
        i_host.put(8'h00, 8'h40);
        tick(1);
        chk(8'(gpo_oe), 8'h01);
        i_host.put(8'h00, 8'h00);
        tick(1);
        chk(8'(gpo_oe), 8'h00);
        // init, then second reset
        i_host.put(8'h03, 8'hff);
        i_host.put(8'h06, 8'h22);
        i_host.put(8'h00, 8'h81);
        rc(8'h00, 8'h08);
        rc(8'h03, 8'h00);
        rc(8'h06, 8'h01);
        i_host.put(8'h05, 8'h00);
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        rc(8'h05, 8'h14);
        give_verdict();
    end
endmodule : tb
